// [rtl/bsu_branch_skip_unit.sv]
// What this block does
// - compare immediate subtracts constant, no writeback, sets Z N V C H, one cycle
// - register bit zero skips next instruction, pc plus 2 or 3, 1-3 cycles
// - io bit one skips next instruction, pc plus 2 or 3
// - io bit zero skips next instruction, else pc plus one
// - selected flag one branches to pc plus offset plus one, 1 or 2 cycles
// - selected flag zero branches to pc plus offset plus one, else falls through
// - carry zero branch taken on clear carry; carry one variant on set carry
// - unsigned same-or-higher branch taken when carry is zero
// - signed greater-or-equal branch taken when N xor V is zero
// - signed less-than branch taken when N xor V is one
// - half-carry branch taken when half-carry flag is one
// - transfer branch taken when transfer flag is one, else sequential
// - transfer-cleared branch taken when transfer flag is zero
`timescale 1ns/1ps
`default_nettype none
`include "bsu_defines.svh"

module bsu_branch_skip_unit #(
	parameter int PC_W  = 12,
	parameter int OFS_W = 7,
	parameter int CNT_W = 16
) (
	input  wire logic                 clk_sys,
	input  wire logic                 srst,
	// apb slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [`BSU_AW-1:0]   paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	// decoder side
	input  wire logic                 instr_valid,
	output logic                      instr_ready,
	input  wire bsu_pkg::bsu_op_t     instr_op,
	input  wire logic [7:0]           reg_value,
	input  wire logic [7:0]           imm_value,
	input  wire logic [7:0]           io_value,
	input  wire logic [2:0]           bit_sel,
	input  wire logic [OFS_W-1:0]     branch_offset,
	input  wire logic                 next_two_word,
	input  wire logic [PC_W-1:0]      pc_in,
	// program counter and flags side
	output logic                      done,
	output logic                      pc_load,
	output logic      [PC_W-1:0]      pc_next,
	output logic                      taken,
	output logic      [7:0]           status_flags
);
	import bsu_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		bsu_state_t       st;
		logic [1:0]       cnt;
		logic [1:0]       cyc;
		logic             done;
		logic             taken;
		logic [PC_W-1:0]  pc;
		logic [7:0]       flags;
		logic             en;
		logic [CNT_W-1:0] count;
		logic [31:0]      rdata;
		logic             slverr;
	} bsu_regs_t;

	bsu_regs_t r_q;
	bsu_regs_t r_d;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// one bit of a byte, shared by skips and flag branches
	function automatic logic bit_at(input logic [7:0] v, input logic [2:0] i);
		bit_at = v[i];
	endfunction : bit_at

	// pc arithmetic wraps at PC_W bits, like the real counter
	function automatic logic [PC_W-1:0] pc_step(input logic [PC_W-1:0] pc,
		input logic [1:0] step);
		pc_step = pc + PC_W'(step);
	endfunction : pc_step

	// ----------------------------------------
	// compare and condition decode
	// ----------------------------------------
	logic [7:0]      cmp_res;
	logic [7:0]      cmp_flags;
	logic            cond;
	logic            is_skip;
	logic            is_branch;
	logic [PC_W-1:0] ofs_ext;
	logic [PC_W-1:0] target;
	logic [1:0]      skip_step;
	logic            n_xor_v;
	logic            fc;
	logic            fh;
	logic            ft;

	// flag taps from the stored status byte
	assign fc      = r_q.flags[`BSU_F_C];
	assign fh      = r_q.flags[`BSU_F_H];
	assign ft      = r_q.flags[`BSU_F_T];
	assign n_xor_v = r_q.flags[`BSU_F_N] ^ r_q.flags[`BSU_F_V];

	assign ofs_ext = {{(PC_W-OFS_W){branch_offset[OFS_W-1]}}, branch_offset};
	// taken target is pc plus offset plus one
	assign target  = pc_step(pc_in + ofs_ext, `BSU_STEP_ONE);
	// length of the instruction being stepped over decides 2 or 3
	assign skip_step = next_two_word ? `BSU_STEP_THREE : `BSU_STEP_TWO;

	always_comb begin
		// carry and half carry are borrows out of bit 7 and bit 3
		cmp_res   = reg_value - imm_value;
		cmp_flags = r_q.flags;
		cmp_flags[`BSU_F_Z] = (cmp_res == 8'h00);
		cmp_flags[`BSU_F_N] = cmp_res[7];
		cmp_flags[`BSU_F_V] = (reg_value[7] & ~imm_value[7] & ~cmp_res[7]) |
			(~reg_value[7] & imm_value[7] & cmp_res[7]);
		cmp_flags[`BSU_F_C] = (~reg_value[7] & imm_value[7]) |
			(imm_value[7] & cmp_res[7]) | (cmp_res[7] & ~reg_value[7]);
		cmp_flags[`BSU_F_H] = (~reg_value[3] & imm_value[3]) |
			(imm_value[3] & cmp_res[3]) | (cmp_res[3] & ~reg_value[3]);
	end

	// condition per operation; flags read as they stand at issue
	always_comb begin
		cond      = 1'b0;
		is_skip   = 1'b0;
		is_branch = 1'b1;
		case (instr_op)
			BSU_OP_CMP_IMM: begin
				is_branch = 1'b0;
			end
			BSU_OP_SKIP_REG_BIT_CLEAR: begin
				is_branch = 1'b0;
				is_skip   = 1'b1;
				cond      = ~bit_at(reg_value, bit_sel);
			end
			// register bit set skip, the mirror of the clear form
			BSU_OP_SKIP_REG_BIT_SET: begin
				is_branch = 1'b0;
				is_skip   = 1'b1;
				cond      = bit_at(reg_value, bit_sel);
			end
			BSU_OP_SKIP_IO_BIT_CLEAR: begin
				is_branch = 1'b0;
				is_skip   = 1'b1;
				cond      = ~bit_at(io_value, bit_sel);
			end
			BSU_OP_SKIP_IO_BIT_SET: begin
				is_branch = 1'b0;
				is_skip   = 1'b1;
				cond      = bit_at(io_value, bit_sel);
			end
			BSU_OP_BRANCH_FLAG_SET: begin
				cond = bit_at(r_q.flags, bit_sel);
			end
			BSU_OP_BRANCH_FLAG_CLEAR: begin
				cond = ~bit_at(r_q.flags, bit_sel);
			end
			BSU_OP_BRANCH_CARRY_ONE: begin
				cond = fc;
			end
			BSU_OP_BRANCH_CARRY_ZERO: begin
				cond = ~fc;
			end
			BSU_OP_BRANCH_UNSIGNED_GE: begin
				cond = ~fc;
			end
			BSU_OP_BRANCH_SIGNED_GE: begin
				cond = ~n_xor_v;
			end
			BSU_OP_BRANCH_SIGNED_LT: begin
				cond = n_xor_v;
			end
			BSU_OP_BRANCH_HALFCARRY_ONE: begin
				cond = fh;
			end
			BSU_OP_BRANCH_TRANSFER_ONE: begin
				cond = ft;
			end
			BSU_OP_BRANCH_TRANSFER_ZERO: begin
				cond = ~ft;
			end
			default: begin
				is_branch = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// handshake and apb decode
	// ----------------------------------------
	logic accept;
	logic apb_setup;
	logic apb_wr;

	// no new instruction while one is still counting down
	// valid while busy or disabled is ignored, nothing is queued
	assign instr_ready = r_q.en & (r_q.st == BSU_ST_IDLE);
	assign accept      = instr_valid & instr_ready;
	assign apb_setup   = psel & ~penable;
	assign apb_wr      = psel & penable & pwrite;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		// one instruction in flight at a time; done lasts one cycle
		r_d      = r_q;
		r_d.done = 1'b0;

		// read data captured in setup so prdata comes from a flop
		if (apb_setup) begin
			r_d.slverr = 1'b0;
			case (paddr)
				`BSU_ADDR_CTRL:  r_d.rdata = {31'h0, r_q.en};
				`BSU_ADDR_FLAGS: r_d.rdata = {24'h0, r_q.flags};
				`BSU_ADDR_LAST: begin
					r_d.rdata = 32'h0;
					r_d.rdata[`BSU_LAST_TAKEN] = r_q.taken;
					r_d.rdata[`BSU_LAST_BUSY]  = (r_q.st == BSU_ST_EXEC);
					r_d.rdata[`BSU_LAST_CYC_LSB +: 2] = r_q.cyc;
				end
				`BSU_ADDR_COUNT: r_d.rdata = 32'(r_q.count);
				default: begin
					r_d.rdata  = 32'h0;
					r_d.slverr = 1'b1;
				end
			endcase
		end

		// software writes; a flag update from an instruction below wins
		// the last-instruction word is read only, a write there is dropped quietly
		if (apb_wr) begin
			case (paddr)
				`BSU_ADDR_CTRL:  r_d.en    = pwdata[`BSU_CTRL_EN_BIT];
				`BSU_ADDR_FLAGS: r_d.flags = pwdata[7:0];
				`BSU_ADDR_COUNT: r_d.count = '0;
				default: ;
			endcase
		end

		case (r_q.st)
			BSU_ST_IDLE: begin
				if (accept) begin
					r_d.st    = BSU_ST_EXEC;
					r_d.taken = cond;
					if (is_skip) begin
						// skip steps over one or two words
						r_d.pc  = cond ? pc_step(pc_in, skip_step)
							: pc_step(pc_in, `BSU_STEP_ONE);
						r_d.cyc = cond ? (next_two_word ? `BSU_CYC_THREE
							: `BSU_CYC_TWO) : `BSU_CYC_ONE;
					end else if (is_branch) begin
						// taken long, untaken short, flags kept
						r_d.pc  = cond ? target : pc_step(pc_in, `BSU_STEP_ONE);
						r_d.cyc = cond ? `BSU_CYC_TWO : `BSU_CYC_ONE;
					end else begin
						r_d.flags = cmp_flags;
						r_d.pc    = pc_step(pc_in, `BSU_STEP_ONE);
						r_d.cyc   = `BSU_CYC_ONE;
					end
					// EXEC cycles left to wait after the first one
					r_d.cnt = r_d.cyc - `BSU_CYC_ONE;
					if (cond) begin
						r_d.count = r_q.count + CNT_W'(1);
					end
				end
			end
			BSU_ST_EXEC: begin
				// last counted cycle: pulse done and free the port
				if (r_q.cnt == '0) begin
					r_d.st   = BSU_ST_IDLE;
					r_d.done = 1'b1;
				end else begin
					// still stepping over words or settling the new pc
					r_d.cnt = r_q.cnt - `BSU_CYC_ONE;
				end
			end
			default: begin
				r_d.st = BSU_ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			r_q        <= '0;
			r_q.st     <= BSU_ST_IDLE;
			// port comes up enabled so the decoder needs no setup write
			r_q.en     <= `BSU_CTRL_RST;
			r_q.flags  <= `BSU_FLAGS_RST;
		end else begin
			r_q <= r_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// apb answers at once; the error only shows in the access phase
	assign prdata       = r_q.rdata;
	assign pready       = 1'b1;
	assign pslverr      = r_q.slverr & psel & penable;

	// done and pc_load are one pulse; pc_next and taken stand until the next accept
	assign done         = r_q.done;
	assign pc_load      = r_q.done;
	assign pc_next      = r_q.pc;
	assign taken        = r_q.taken;

	// flags as stored; branches read these, never a compare still in flight
	assign status_flags = r_q.flags;

endmodule : bsu_branch_skip_unit
`default_nettype wire

// [rtl/bsu_defines.svh]
`ifndef BSU_DEFINES_SVH
`define BSU_DEFINES_SVH

// ----------------------------------------
// register map (byte addresses, 32-bit words)
// ----------------------------------------
`define BSU_AW            8
`define BSU_ADDR_CTRL     8'h00
`define BSU_ADDR_FLAGS    8'h04
`define BSU_ADDR_LAST     8'h08
`define BSU_ADDR_COUNT    8'h0c

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define BSU_CTRL_EN_BIT   0
`define BSU_CTRL_RST      1'b1
`define BSU_FLAGS_RST     8'h00
`define BSU_LAST_TAKEN    0
`define BSU_LAST_BUSY     1
`define BSU_LAST_CYC_LSB  8

// ----------------------------------------
// status flag bit positions
// ----------------------------------------
`define BSU_F_C           3'd0
`define BSU_F_Z           3'd1
`define BSU_F_N           3'd2
`define BSU_F_V           3'd3
`define BSU_F_H           3'd5
`define BSU_F_T           3'd6

// ----------------------------------------
// cycle counts and program counter steps
// ----------------------------------------
`define BSU_CYC_ONE       2'd1
`define BSU_CYC_TWO       2'd2
`define BSU_CYC_THREE     2'd3
`define BSU_STEP_ONE      2'd1
`define BSU_STEP_TWO      2'd2
`define BSU_STEP_THREE    2'd3

`endif

// [rtl/bsu_pkg.sv]
package bsu_pkg;

	// ----------------------------------------
	// operation select from the decoder
	// ----------------------------------------
	typedef enum logic [3:0] {
		BSU_OP_CMP_IMM            = 4'h0,
		BSU_OP_SKIP_REG_BIT_CLEAR = 4'h1,
		BSU_OP_SKIP_REG_BIT_SET   = 4'h2,
		BSU_OP_SKIP_IO_BIT_CLEAR  = 4'h3,
		BSU_OP_SKIP_IO_BIT_SET    = 4'h4,
		BSU_OP_BRANCH_FLAG_SET    = 4'h5,
		BSU_OP_BRANCH_FLAG_CLEAR  = 4'h6,
		BSU_OP_BRANCH_CARRY_ONE   = 4'h7,
		BSU_OP_BRANCH_CARRY_ZERO  = 4'h8,
		BSU_OP_BRANCH_UNSIGNED_GE = 4'h9,
		BSU_OP_BRANCH_SIGNED_GE   = 4'ha,
		BSU_OP_BRANCH_SIGNED_LT   = 4'hb,
		BSU_OP_BRANCH_HALFCARRY_ONE = 4'hc,
		BSU_OP_BRANCH_TRANSFER_ONE  = 4'hd,
		BSU_OP_BRANCH_TRANSFER_ZERO = 4'he
	} bsu_op_t;

	// ----------------------------------------
	// control states, one-hot
	// ----------------------------------------
	typedef enum logic [1:0] {
		BSU_ST_IDLE = 2'b01,
		BSU_ST_EXEC = 2'b10
	} bsu_state_t;

endpackage : bsu_pkg

// [verif/bsu_pc_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// program counter on the far side
// ----
module bsu_pc_model #(
	parameter int              PC_W  = 12,
	parameter logic [PC_W-1:0] START = 12'h010
) (
	input  wire logic            clk_sys,
	input  wire logic            srst,
	input  wire logic            pc_load,
	input  wire logic [PC_W-1:0] pc_next,
	output logic      [PC_W-1:0] pc_q
);
	// follows only announced loads, so a stray pulse shows up as a wrong address later
	always_ff @(posedge clk_sys) begin
		if (srst)
			pc_q <= START;
		else if (pc_load)
			pc_q <= pc_next;
	end
endmodule : bsu_pc_model
`default_nettype wire

// [verif/bsu_chk_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// port checker
// ----
module bsu_chk
	import bsu_pkg::*;
#(
	parameter int PC_W  = 12,
	parameter int OFS_W = 7
) (
	input wire logic             clk_sys,
	input wire logic             srst,
	input wire logic             psel,
	input wire logic             penable,
	input wire logic             pwrite,
	input wire logic             instr_valid,
	input wire logic             instr_ready,
	input wire bsu_op_t          instr_op,
	input wire logic [7:0]       reg_value,
	input wire logic [7:0]       imm_value,
	input wire logic [7:0]       io_value,
	input wire logic [2:0]       bit_sel,
	input wire logic [OFS_W-1:0] branch_offset,
	input wire logic             next_two_word,
	input wire logic [PC_W-1:0]  pc_in,
	input wire logic             done,
	input wire logic [PC_W-1:0]  pc_next,
	input wire logic             taken,
	input wire logic [7:0]       status_flags
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	// accept strobe, widened offset and signed condition
	logic            acc;
	logic [PC_W-1:0] ofs;
	logic            nv;
	assign acc = instr_valid && instr_ready;
	assign ofs = PC_W'($signed(branch_offset));
	assign nv  = status_flags[2] ^ status_flags[3];

	AST_CMP_TIME: assert property (acc && instr_op == BSU_OP_CMP_IMM |=>
		!done ##1 done && pc_next == PC_W'($past(pc_in, 2) + 1)) else $error("compare timing");
	AST_CMP_FLAGS: assert property (acc && instr_op == BSU_OP_CMP_IMM |=>
		status_flags[1] == ($past(reg_value) == $past(imm_value)) &&
		status_flags[0] == ($past(reg_value) < $past(imm_value))) else $error("compare flags");
	AST_SKIP_REG: assert property (acc && instr_op == BSU_OP_SKIP_REG_BIT_CLEAR &&
		!reg_value[bit_sel] && !next_two_word |=> !done[*2] ##1 done && taken &&
		pc_next == PC_W'($past(pc_in, 3) + 2)) else $error("register skip");
	AST_SKIP_IO: assert property (acc && instr_op == BSU_OP_SKIP_IO_BIT_SET &&
		io_value[bit_sel] && next_two_word |-> ##4 done &&
		pc_next == PC_W'($past(pc_in, 4) + 3)) else $error("io skip");
	AST_IO_CLR_NO: assert property (acc && instr_op == BSU_OP_SKIP_IO_BIT_CLEAR &&
		io_value[bit_sel] |=> !done ##1 done && !taken) else $error("io no skip");
	AST_FLAG_NO: assert property (acc && instr_op == BSU_OP_BRANCH_FLAG_SET &&
		!status_flags[bit_sel] |=> !done ##1 done && !taken &&
		pc_next == PC_W'($past(pc_in, 2) + 1)) else $error("flag branch");
	AST_GE: assert property (acc && instr_op == BSU_OP_BRANCH_SIGNED_GE && !nv |->
		##3 done && taken && pc_next == PC_W'($past(pc_in, 3) + $past(ofs, 3) + 1))
		else $error("signed ge");
	AST_LT: assert property (acc && instr_op == BSU_OP_BRANCH_SIGNED_LT && nv |=>
		!done[*2] ##1 done && taken) else $error("signed lt");
	AST_KEEP: assert property (acc && instr_op != BSU_OP_CMP_IMM &&
		!(psel && penable && pwrite) |=> $stable(status_flags)) else $error("flags moved");

	cover property (acc && instr_op == BSU_OP_CMP_IMM);
	cover property (done && taken);
	cover property (done && !taken);
endmodule : bsu_chk

bind bsu_branch_skip_unit bsu_chk #(.PC_W(PC_W), .OFS_W(OFS_W)) bsu_chk_i (.*);
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
	$display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module testbench;
	import bsu_pkg::*;
	logic        clk_sys, srst, psel, penable, pwrite, pready, pslverr, er;
	logic        instr_valid, instr_ready, next_two_word, done, pc_load, taken;
	logic [7:0]  paddr, reg_value, imm_value, io_value, status_flags;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0]  bit_sel;
	logic [6:0]  branch_offset;
	logic [11:0] pc_in, pc_next;
	bsu_op_t     instr_op;
	int          mismatches, checks, cyc, cnt;

	bsu_branch_skip_unit bsu_branch_skip_unit_i (.*);
	bsu_pc_model bsu_pc_model_i (.clk_sys, .srst, .pc_load, .pc_next, .pc_q(pc_in));

	// ----
	// clock, hang guard, verdict
	// ----
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			report_and_stop;
		end
	end
	task report_and_stop;
		$display("mismatches=%0d checks=%0d", mismatches, checks);
		if (mismatches == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop

	// ----
	// bus and instruction drivers
	// ----
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb
	// expected step worked out here, not taken from the design
	task ins(input bsu_op_t op, input logic [7:0] rv, iv, input logic [2:0] b,
		input logic [6:0] k, input logic w2, t, input int n);
		logic [11:0] pc0, st;
		int          c;
		@(posedge clk_sys);
		instr_valid <= 1'b1;
		instr_op <= op;
		{reg_value, imm_value, io_value} <= {rv, iv, iv};
		{bit_sel, branch_offset, next_two_word} <= {b, k, w2};
		do @(posedge clk_sys); while (instr_ready !== 1'b1);
		pc0 = pc_in;
		instr_valid <= 1'b0;
		c = 0;
		do begin
			@(posedge clk_sys);
			c++;
		end while (done !== 1'b1 && c < 9);
		st = !t ? 12'h001 : op >= BSU_OP_BRANCH_FLAG_SET ? {{5{k[6]}}, k} + 12'h001 :
			w2 ? 12'h003 : 12'h002;
		`CHK(c, n + 1)
		`CHK(pc_next, pc0 + st)
		if (op != BSU_OP_CMP_IMM)
			`CHK(taken, t)
		cnt += int'(t);
	endtask : ins
	function logic cnd(input int o, input logic [7:0] f);
		case (o)
			5: return f[o[2:0]];
			6: return !f[o[2:0]];
			7: return f[0];
			8, 9: return !f[0];
			10: return !(f[2] ^ f[3]);
			11: return f[2] ^ f[3];
			12: return f[5];
			13: return f[6];
			default: return !f[6];
		endcase
	endfunction : cnd

	// ----
	// scenarios
	// ----
	task t_regs;
		apb(1'b0, 8'h00, 32'h0);
		`CHK(rd, 32'h1)
		apb(1'b0, 8'h10, 32'h0);
		`CHK({er, rd}, {1'b1, 32'h0})
		apb(1'b1, 8'h00, 32'h0);
		@(posedge clk_sys);
		`CHK(instr_ready, 1'b0)
		apb(1'b1, 8'h00, 32'h1);
	endtask : t_regs
	task t_cmp;
		ins(BSU_OP_CMP_IMM, 8'h05, 8'h05, 3'h0, 7'h00, 1'b0, 1'b0, 1);
		`CHK(status_flags, 8'h02)
		ins(BSU_OP_CMP_IMM, 8'h80, 8'h01, 3'h0, 7'h00, 1'b0, 1'b0, 1);
		`CHK(status_flags, 8'h28)
		ins(BSU_OP_CMP_IMM, 8'h03, 8'h05, 3'h0, 7'h00, 1'b0, 1'b0, 1);
		`CHK(status_flags, 8'h25)
	endtask : t_cmp
	task t_skip;
		ins(BSU_OP_SKIP_REG_BIT_CLEAR, 8'hef, 8'h00, 3'h4, 7'h00, 1'b0, 1'b1, 2);
		ins(BSU_OP_SKIP_REG_BIT_CLEAR, 8'h10, 8'h00, 3'h4, 7'h00, 1'b1, 1'b0, 1);
		ins(BSU_OP_SKIP_REG_BIT_SET, 8'h10, 8'h00, 3'h4, 7'h00, 1'b0, 1'b1, 2);
		ins(BSU_OP_SKIP_IO_BIT_SET, 8'h00, 8'h80, 3'h7, 7'h00, 1'b1, 1'b1, 3);
		ins(BSU_OP_SKIP_IO_BIT_CLEAR, 8'h00, 8'hfe, 3'h0, 7'h00, 1'b1, 1'b1, 3);
		ins(BSU_OP_SKIP_IO_BIT_CLEAR, 8'h00, 8'h01, 3'h0, 7'h00, 1'b0, 1'b0, 1);
	endtask : t_skip
	task t_br(input logic [7:0] f);
		apb(1'b1, 8'h04, {24'h0, f});
		for (int o = 5; o < 15; o++)
			ins(bsu_op_t'(o), 8'h00, 8'h00, 3'(o), 7'h7e, 1'b0, cnd(o, f), cnd(o, f) ? 2 : 1);
		`CHK(status_flags, f)
	endtask : t_br

	initial begin
		{psel, penable, pwrite, instr_valid, next_two_word} = 5'h00;
		{paddr, pwdata, reg_value, imm_value, io_value} = 64'h0;
		{bit_sel, branch_offset} = 10'h000;
		instr_op = BSU_OP_CMP_IMM;
		srst = 1'b1;
		repeat (20) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		t_regs;
		t_cmp;
		apb(1'b1, 8'h0c, 32'h0);
		cnt = 0;
		t_skip;
		t_br(8'h00);
		t_br(8'h69);
		ins(BSU_OP_BRANCH_CARRY_ONE, 8'h00, 8'h00, 3'h0, 7'h3f, 1'b0, 1'b1, 2);
		ins(BSU_OP_BRANCH_CARRY_ONE, 8'h00, 8'h00, 3'h0, 7'h40, 1'b0, 1'b1, 2);
		apb(1'b0, 8'h0c, 32'h0);
		`CHK(rd, 32'(cnt))
		apb(1'b0, 8'h08, 32'h0);
		`CHK(rd, 32'h0000_0201)
		apb(1'b0, 8'h04, 32'h0);
		`CHK(rd, 32'h0000_0069)
		report_and_stop;
	end
endmodule : testbench
`default_nettype wire
